// ---- core/timer_flag_skip.sv ----
// Timer flag skip sequencer with AXI4-Lite register access
`timescale 1ns/1ps

module timer_flag_skip (
   input  wire logic                             ref_clk,
   input  wire logic                             rst,
   input  tmr_skip_pkg::axil_req_t               axiReq,
   output tmr_skip_pkg::axil_rsp_t               axiRsp,
   input  wire logic                             instrValid,
   input  wire logic [tmr_skip_pkg::INSTR_W-1:0] instrWord,
   input  wire logic                             timerAEvent,
   input  wire logic                             timerBEvent,
   output logic                                  execValid,
   output logic [tmr_skip_pkg::INSTR_W-1:0]      execWord,
   output logic                                  execSquash,
   output logic                                  timerAIrqFlag,
   output logic                                  timerBIrqFlag
);

   typedef struct packed {
      logic                                  awHeld;
      logic [31:0]                           awAddr;
      logic                                  wHeld;
      logic [31:0]                           wData;
      logic [3:0]                            wStrb;
      tmr_skip_pkg::axil_rsp_t               rsp;
      logic [tmr_skip_pkg::IRQ_CTRL_W-1:0]   irqCtrl;
      logic                                  flagA;
      logic                                  flagB;
      logic                                  skipPending;
      logic [tmr_skip_pkg::CNT_W-1:0]        skipCount;
      logic                                  execValid;
      logic [tmr_skip_pkg::INSTR_W-1:0]      execWord;
      logic                                  execSquash;
   } state_t;

   state_t                  q;
   state_t                  d;
   tmr_skip_pkg::skip_dec_t dec;
   logic                    swClrA;
   logic                    swClrB;
   logic                    liveInstr;

   // Decode against the flags as they stand this cycle
   skip_decode u_dec (
      .instrWord        (instrWord),
      .irqControlRegOne (q.irqCtrl),
      .timerAIrqFlag    (q.flagA),
      .timerBIrqFlag    (q.flagB),
      .dec              (dec)
   );

   // Read data for one register offset
   function automatic logic [31:0] readReg(input logic [31:0] addr,
                                           input state_t      s);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (addr == tmr_skip_pkg::OFS_IRQ_CTRL) begin
         v[tmr_skip_pkg::IRQ_CTRL_W-1:0] = s.irqCtrl;
      end else if (addr == tmr_skip_pkg::OFS_FLAGS) begin
         v[tmr_skip_pkg::FLAG_A_BIT] = s.flagA;
         v[tmr_skip_pkg::FLAG_B_BIT] = s.flagB;
      end else if (addr == tmr_skip_pkg::OFS_STATUS) begin
         v[tmr_skip_pkg::PEND_BIT] = s.skipPending;
         v[tmr_skip_pkg::CNT_LSB +: tmr_skip_pkg::CNT_W] = s.skipCount;
      end
      return v;
   endfunction

   // True for any offset that the block maps
   function automatic logic isMapped(input logic [31:0] addr);
      return (addr == tmr_skip_pkg::OFS_IRQ_CTRL) ||
             (addr == tmr_skip_pkg::OFS_FLAGS) ||
             (addr == tmr_skip_pkg::OFS_STATUS);
   endfunction

   // A skip-marked instruction is swallowed, so it may not act itself
   assign liveInstr = instrValid && !q.skipPending;

   // Next state: bus slave, flags and instruction sequencing
   always_comb begin
      d = q;
      swClrA = 1'b0;
      swClrB = 1'b0;

      // Write channel: address and data accepted in either order
      if (axiReq.bready && q.rsp.bvalid) begin
         d.rsp.bvalid = 1'b0;
      end
      if (axiReq.awvalid && q.rsp.awready) begin
         d.awHeld = 1'b1;
         d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && q.rsp.wready) begin
         d.wHeld = 1'b1;
         d.wData = axiReq.wdata;
         d.wStrb = axiReq.wstrb;
      end
      if (d.awHeld && d.wHeld && !d.rsp.bvalid) begin
         d.awHeld = 1'b0;
         d.wHeld = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = tmr_skip_pkg::RESP_OKAY;
         if (!isMapped(d.awAddr)) begin
            d.rsp.bresp = tmr_skip_pkg::RESP_SLVERR;
         end else if (d.awAddr == tmr_skip_pkg::OFS_IRQ_CTRL) begin
            if (d.wStrb[0]) begin
               d.irqCtrl = d.wData[tmr_skip_pkg::IRQ_CTRL_W-1:0];
            end
         end else if (d.awAddr == tmr_skip_pkg::OFS_FLAGS) begin
            // Write one to clear
            swClrA = d.wStrb[0] && d.wData[tmr_skip_pkg::FLAG_A_BIT];
            swClrB = d.wStrb[0] && d.wData[tmr_skip_pkg::FLAG_B_BIT];
         end
      end
      // Ready only while nothing is parked, so a beat is never dropped
      d.rsp.awready = !d.awHeld && !d.rsp.bvalid;
      d.rsp.wready = !d.wHeld && !d.rsp.bvalid;

      // Read channel: one read in flight, answered from registers
      if (axiReq.rready && q.rsp.rvalid) begin
         d.rsp.rvalid = 1'b0;
      end
      if (axiReq.arvalid && q.rsp.arready) begin
         d.rsp.rvalid = 1'b1;
         d.rsp.rdata = readReg(axiReq.araddr, q);
         d.rsp.rresp = isMapped(axiReq.araddr) ? tmr_skip_pkg::RESP_OKAY
                                               : tmr_skip_pkg::RESP_SLVERR;
      end
      d.rsp.arready = !d.rsp.rvalid;

      // One machine cycle per word; a swallowed word is issued marked and only clears the pending skip
      d.execValid = instrValid;
      if (instrValid) begin
         d.execWord = instrWord;
         d.execSquash = q.skipPending;
         d.skipPending = liveInstr && dec.takeSkip;
         if (liveInstr && dec.takeSkip) begin
            d.skipCount = q.skipCount + 8'h01;
         end
      end

      // Timer events win over any clear in the same cycle
      d.flagA = timerAEvent ||
                (q.flagA && !swClrA && !(liveInstr && dec.clrA));
      d.flagB = timerBEvent ||
                (q.flagB && !swClrB && !(liveInstr && dec.clrB));
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= '0;
         q.irqCtrl <= tmr_skip_pkg::IRQ_CTRL_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from the state register
   assign axiRsp = q.rsp;
   assign execValid = q.execValid;
   assign execWord = q.execWord;
   assign execSquash = q.execSquash;
   assign timerAIrqFlag = q.flagA;
   assign timerBIrqFlag = q.flagB;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Live timer B skip with flag set and gate clear marks the next word
   AST_B_SKIP: assert property (
      (liveInstr && instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_B &&
       !q.irqCtrl[tmr_skip_pkg::GATE_B_BIT] && q.flagB)
      |=> q.skipPending && $changed(q.skipCount)
   ) else $error("timer B skip did not mark next word");

   // Timer B flag clears after its skip unless a new event lands
   AST_B_CLEAR: assert property (
      (liveInstr && instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_B &&
       !q.irqCtrl[tmr_skip_pkg::GATE_B_BIT] && q.flagB && !timerBEvent)
      |=> !timerBIrqFlag
   ) else $error("timer B flag not cleared after skip");

   // Clear timer B flag means the following word runs
   AST_B_NOSKIP: assert property (
      (liveInstr && instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_B && !q.flagB)
      |=> !q.skipPending
   ) else $error("timer B skip taken with flag clear");

   // Gate bit set: no skip and the flag is left standing
   AST_B_GATED: assert property (
      (liveInstr && instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_B &&
       q.irqCtrl[tmr_skip_pkg::GATE_B_BIT] && q.flagB && !swClrB)
      |=> !q.skipPending && timerBIrqFlag
   ) else $error("gated timer B skip acted");

   // Timer A skip with gate clear and flag set marks the next word
   AST_A_SKIP: assert property (
      (liveInstr && instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_A &&
       !q.irqCtrl[tmr_skip_pkg::GATE_A_BIT] && q.flagA)
      |=> q.skipPending && $changed(q.skipCount)
   ) else $error("timer A skip did not mark next word");

   // Timer A flag clears after skip, and a clear flag gives no skip
   AST_A_CLEAR: assert property (
      (liveInstr && instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_A &&
       !q.irqCtrl[tmr_skip_pkg::GATE_A_BIT] && !timerAEvent)
      |=> !timerAIrqFlag && (q.skipPending == $past(q.flagA))
   ) else $error("timer A flag or skip wrong");

   // A swallowed word is passed on marked and leaves the timer A flag alone
   AST_SQUASH: assert property (
      (instrValid && q.skipPending && q.flagA && !swClrA)
      |=> execValid && execSquash && !q.skipPending && timerAIrqFlag
   ) else $error("skipped word was not swallowed cleanly");

   // Timer A gate blocks the skip
   AST_A_GATED: assert property (
      (liveInstr && instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_A &&
       q.irqCtrl[tmr_skip_pkg::GATE_A_BIT])
      |=> !q.skipPending
   ) else $error("gated timer A skip acted");

   // Word behind a pending skip comes out marked, then the mark is gone
   AST_NEXT_SQUASHED: assert property (
      (instrValid && q.skipPending)
      |=> execValid && execSquash && !q.skipPending
   ) else $error("word behind a skip was not marked");

   // A word with no skip pending runs unmarked
   AST_LIVE_RUNS: assert property (
      liveInstr |=> execValid && !execSquash
   ) else $error("live word was marked as skipped");

   // Every word issues exactly one cycle later
   AST_EXEC_ONE: assert property (
      instrValid |=> execValid && (execWord == $past(instrWord))
   ) else $error("word not issued one cycle later");

   // No word, no issue; the last word stays on view
   AST_EXEC_IDLE: assert property (
      !instrValid |=> !execValid && $stable(execWord) && $stable(execSquash)
   ) else $error("issue without a word");

   // Set beats clear, so an event is never lost to a skip
   AST_A_EVENT: assert property (
      timerAEvent |=> timerAIrqFlag
   ) else $error("timer A event lost");

   // Same for the timer B flag
   AST_B_EVENT: assert property (
      timerBEvent |=> timerBIrqFlag
   ) else $error("timer B event lost");

   // First edge after reset: everything still quiet
   AST_RST_QUIET: assert property (
      $past(rst) |-> !axiRsp.awready && !axiRsp.wready && !axiRsp.arready &&
                     !axiRsp.bvalid && !axiRsp.rvalid && !execValid &&
                     !timerAIrqFlag && !timerBIrqFlag &&
                     (q.irqCtrl == tmr_skip_pkg::IRQ_CTRL_RST)
   ) else $error("outputs not quiet after reset");

   // Readies come up one edge after reset
   AST_RST_READY: assert property (
      $past(rst) |=> axiRsp.awready && axiRsp.wready && axiRsp.arready
   ) else $error("bus not ready after reset");

   // Write answer stands until the master takes it
   AST_B_HOLD: assert property (
      axiRsp.bvalid && !axiReq.bready
      |=> axiRsp.bvalid && $stable(axiRsp.bresp)
   ) else $error("write answer dropped early");

   // Read answer stands until the master takes it
   AST_R_HOLD: assert property (
      axiRsp.rvalid && !axiReq.rready
      |=> axiRsp.rvalid && $stable(axiRsp.rdata) && $stable(axiRsp.rresp)
   ) else $error("read answer dropped early");

   // Both write beats taken together: answer on the next edge
   AST_B_ANSWER: assert property (
      axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
      |=> axiRsp.bvalid
   ) else $error("write answer late");

   // Read address taken: data on the next edge
   AST_R_ANSWER: assert property (
      axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid
   ) else $error("read answer late");

   // No new beats while an answer waits, so none can be dropped
   AST_BUSY_REFUSE: assert property (
      !(axiRsp.bvalid && (axiRsp.awready || axiRsp.wready)) &&
      !(axiRsp.rvalid && axiRsp.arready)
   ) else $error("bus ready while an answer waits");

endmodule

// ---- core/tmr_skip_pkg.sv ----
// Shared constants and carrier types for the timer flag skip decoder
package tmr_skip_pkg;

   // Instruction word layout
   localparam int INSTR_W = 10;
   localparam logic [INSTR_W-1:0] OPC_SKIP_TIMER_A = 10'h280;
   localparam logic [INSTR_W-1:0] OPC_SKIP_TIMER_B = 10'h281;

   // Interrupt control register one and its gate bits
   localparam int IRQ_CTRL_W = 4;
   localparam int GATE_A_BIT = 2;
   localparam int GATE_B_BIT = 3;
   localparam logic [IRQ_CTRL_W-1:0] IRQ_CTRL_RST = 4'h0;

   // Register offsets (byte addresses)
   localparam logic [31:0] OFS_IRQ_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_FLAGS    = 32'h0000_0004;
   localparam logic [31:0] OFS_STATUS   = 32'h0000_0008;

   // Field positions in the flag and status registers
   localparam int FLAG_A_BIT  = 0;
   localparam int FLAG_B_BIT  = 1;
   localparam int PEND_BIT    = 0;
   localparam int CNT_LSB     = 8;
   localparam int CNT_W       = 8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_t;

   // Outcome of decoding one instruction word
   typedef struct packed {
      logic takeSkip;
      logic clrA;
      logic clrB;
   } skip_dec_t;

endpackage

// ---- core/skip_decode.sv ----
// Decoder for the two timer flag skip instructions
`timescale 1ns/1ps
module skip_decode (
   input  wire logic [tmr_skip_pkg::INSTR_W-1:0]    instrWord,
   input  wire logic [tmr_skip_pkg::IRQ_CTRL_W-1:0] irqControlRegOne,
   input  wire logic                                timerAIrqFlag,
   input  wire logic                                timerBIrqFlag,
   output tmr_skip_pkg::skip_dec_t                  dec
);

   logic isSkipA;
   logic isSkipB;
   logic gateA;
   logic gateB;

   // A set gate bit turns the instruction into a plain no-operation
   always_comb begin
      isSkipA = (instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_A);
      isSkipB = (instrWord == tmr_skip_pkg::OPC_SKIP_TIMER_B);
      gateA   = irqControlRegOne[tmr_skip_pkg::GATE_A_BIT];
      gateB   = irqControlRegOne[tmr_skip_pkg::GATE_B_BIT];
      dec.clrA = isSkipA && !gateA && timerAIrqFlag;
      dec.clrB = isSkipB && !gateB && timerBIrqFlag;
      dec.takeSkip = dec.clrA || dec.clrB;
   end

endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the timer flag skip sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   num_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   tmr_skip_pkg::axil_req_t req = '0;
   tmr_skip_pkg::axil_rsp_t rsp;
   logic                    ref_clk = 0;
   logic                    rst = 1;
   logic                    iv = 0;
   logic                    ea = 0;
   logic                    eb = 0;
   logic [9:0]              w = '0;
   logic                    xv, xs, fa_o, fb_o;
   logic [9:0]              xw;
   // Reference model state, expected outputs after the next edge
   logic                    fa = 0, fb = 0, pend = 0, eV = 0, eS = 0;
   logic [3:0]              ctl = '0;
   logic [9:0]              eW = '0;
   int                      skips = 0, cyc = 0;
   int                      num_errors = 0, n_checks = 0;

   // 125 MHz core clock
   always #4 ref_clk = ~ref_clk;

   timer_flag_skip i_dut (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .axiReq        (req),
      .axiRsp        (rsp),
      .instrValid    (iv),
      .instrWord     (w),
      .timerAEvent   (ea),
      .timerBEvent   (eb),
      .execValid     (xv),
      .execWord      (xw),
      .execSquash    (xs),
      .timerAIrqFlag (fa_o),
      .timerBIrqFlag (fb_o)
   );

   // Verdict and end of run
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, far above the roughly 1300 cycles of the tests
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end

   // Mostly skip opcodes so that skips and swallowed skips both occur
   function automatic logic [9:0] pick();
      case ($urandom % 4)
         0: pick = tmr_skip_pkg::OPC_SKIP_TIMER_A;
         1: pick = tmr_skip_pkg::OPC_SKIP_TIMER_B;
         2: pick = 10'($urandom);
         default: pick = tmr_skip_pkg::OPC_SKIP_TIMER_B;
      endcase
   endfunction

   // One cycle: drive, check last edge, then advance the model
   task automatic step(input logic v, input logic [9:0] wd,
                       input logic a, input logic b);
      logic ca, cb;
      @(posedge ref_clk);
      iv <= v;
      w <= wd;
      ea <= a;
      eb <= b;
      #1;
      `CHK("execValid", eV, xv)
      `CHK("execWord", eW, xw)
      `CHK("execSquash", eS, xs)
      `CHK("flagA", fa, fa_o)
      `CHK("flagB", fb, fb_o)
      ca = 0;
      cb = 0;
      eV = v;
      if (v) begin
         eW = wd;
         eS = pend;
         if (pend) begin
            pend = 0;
         end else begin
            ca = wd == tmr_skip_pkg::OPC_SKIP_TIMER_A && !ctl[2] && fa;
            cb = wd == tmr_skip_pkg::OPC_SKIP_TIMER_B && !ctl[3] && fb;
            pend = ca | cb;
         end
      end
      // A timer event in the clearing cycle keeps the flag set
      fa = a | (fa & !ca);
      fb = b | (fb & !cb);
      skips += int'(ca | cb);
   endtask

   // AXI4-Lite write, address and data offered together
   task automatic wr(input logic [31:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic ad, dd;
      @(posedge ref_clk);
      req.awvalid <= 1;
      req.awaddr <= a;
      req.wvalid <= 1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1;
      ad = 0;
      dd = 0;
      while (!(ad && dd)) begin
         @(posedge ref_clk);
         if (rsp.awready && !ad) begin
            ad = 1;
            req.awvalid <= 0;
         end
         if (rsp.wready && !dd) begin
            dd = 1;
            req.wvalid <= 0;
         end
      end
      do @(posedge ref_clk); while (!rsp.bvalid);
      req.bready <= 0;
      `CHK("bresp", er, rsp.bresp)
   endtask

   // AXI4-Lite read
   task automatic rd(input logic [31:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge ref_clk);
      req.arvalid <= 1;
      req.araddr <= a;
      req.rready <= 1;
      do @(posedge ref_clk); while (!rsp.arready);
      req.arvalid <= 0;
      do @(posedge ref_clk); while (!rsp.rvalid);
      req.rready <= 0;
      d = rsp.rdata;
      r = rsp.rresp;
   endtask

   // Sweep all gate settings with random instruction traffic
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [3:0]  c;
      void'($urandom(10326));
      repeat (4) @(posedge ref_clk);
      rst <= 0;
      repeat (3) @(posedge ref_clk);
      for (int k = 0; k < 4; k++) begin
         c = {2'(k), 2'($urandom)};
         wr(tmr_skip_pkg::OFS_IRQ_CTRL, {28'h0, c}, tmr_skip_pkg::RESP_OKAY);
         ctl = c;
         rd(tmr_skip_pkg::OFS_IRQ_CTRL, d, r);
         `CHK("ctrl", c, d[3:0])
         repeat (300)
            step($urandom % 4 != 0, pick(), $urandom % 8 == 0,
                 $urandom % 8 == 0);
         step(0, 0, 0, 0);
         step(0, 0, 0, 0);
         rd(tmr_skip_pkg::OFS_STATUS, d, r);
         `CHK("pending", pend, d[0])
         `CHK("skips", 8'(skips), d[15:8])
         rd(tmr_skip_pkg::OFS_FLAGS, d, r);
         `CHK("flags", {fb, fa}, d[1:0])
         c[1:0] = 2'($urandom);
         wr(tmr_skip_pkg::OFS_FLAGS, {30'h0, c[1:0]}, tmr_skip_pkg::RESP_OKAY);
         fa &= !c[0];
         fb &= !c[1];
      end
      // Unmapped place answers with an error and zero data
      rd(32'h0000_0040, d, r);
      `CHK("rresp", tmr_skip_pkg::RESP_SLVERR, r)
      `CHK("rdata", 32'h0, d)
      wr(32'h0000_0044, 32'h0000_000f, tmr_skip_pkg::RESP_SLVERR);
      step(0, 0, 0, 0);
      test_done();
   end
endmodule
